/* File: design/apc_top.sv */
// pin control and framed serial output of the converter
`timescale 1ns/1ps
`default_nettype none
module apc_top
	import apc_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic sample_valid,
	output logic sample_ready,
	input wire logic [IN_BITS-1:0] sample_data,
	input wire logic sync_pin,
	input wire logic power_down_n,
	input wire logic use_internal_vref_n,
	output logic sclk,
	output logic sclk_n,
	output logic dout,
	output logic dout_n,
	output logic frame_marker,
	output logic frame_marker_n,
	output logic range_exceeded,
	output logic internal_vref_on,
	output logic circuit_enable,
	output logic sample_hold
);
	typedef struct packed {
		logic sync_s1;
		logic sync_s2;
		logic sync_s3;
		logic pd_s1;
		logic pd_s2;
		logic vref_s1;
		logic vref_s2;
		apc_state_e state;
		logic [9:0] cnt;
		logic [3:0] bit_idx;
		logic [15:0] shreg;
		logic sclk;
		logic sclk_n;
		logic dout;
		logic dout_n;
		logic frame;
		logic frame_n;
		logic range;
		logic vref_on;
		logic enable;
		logic hold;
	} apc_top_s;

	localparam apc_top_s TOP_RESET = '{
		sync_s1: 1'b0, sync_s2: 1'b0, sync_s3: 1'b0,
		pd_s1: PD_N_RESET, pd_s2: PD_N_RESET,
		vref_s1: VREF_N_RESET, vref_s2: VREF_N_RESET,
		state: APC_OFF, cnt: '0, bit_idx: '0, shreg: '0,
		sclk: 1'b0, sclk_n: 1'b1, dout: 1'b0, dout_n: 1'b1,
		frame: 1'b0, frame_n: 1'b1, range: 1'b0,
		vref_on: 1'b0, enable: 1'b0, hold: 1'b0};

	apc_top_s r_reg;
	apc_top_s r_next;
	logic sync_evt;
	logic fifo_flush;
	logic fifo_in_valid;
	logic [FIFO_WIDTH-1:0] fifo_in_data;
	logic fifo_pop;
	logic fifo_valid;
	logic [FIFO_WIDTH-1:0] fifo_data;

	// start a word: marker, first serial clock rise and msb together
	function automatic apc_top_s load_word(input apc_top_s s, input logic [16:0] w);
		apc_top_s t;
		t = s;
		t.state = APC_SHIFT;
		t.shreg = w[15:0];
		t.dout = w[15];
		t.range = w[16];
		t.bit_idx = '0;
		t.sclk = 1'b1;
		t.frame = 1'b1;
		return t;
	endfunction

	// clamp and tag the incoming result before buffering
	assign fifo_in_data = apc_saturate(sample_data);
	assign fifo_in_valid = sample_valid && r_reg.enable;
	assign sync_evt = r_reg.sync_s2 && !r_reg.sync_s3;
	assign fifo_flush = !r_reg.pd_s2 || sync_evt;

	apc_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.reset(reset),
		.flush(fifo_flush),
		.in_valid(fifo_in_valid),
		.in_ready(sample_ready),
		.in_data(fifo_in_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_data)
	);

	// pin synchronisers, sequencing and serialiser
	always_comb begin
		r_next = r_reg;
		fifo_pop = 1'b0;
		r_next.sync_s1 = sync_pin;
		r_next.sync_s2 = r_reg.sync_s1;
		r_next.sync_s3 = r_reg.sync_s2;
		r_next.pd_s1 = power_down_n;
		r_next.pd_s2 = r_reg.pd_s1;
		r_next.vref_s1 = use_internal_vref_n;
		r_next.vref_s2 = r_reg.vref_s1;
		if (!r_reg.pd_s2) begin
			r_next.state = APC_OFF;
			r_next.sclk = 1'b0;
			r_next.frame = 1'b0;
			r_next.dout = 1'b0;
			r_next.range = 1'b0;
		end else if (sync_evt) begin
			r_next.state = APC_SETTLE;
			r_next.cnt = SETTLE_CLKS;
			r_next.sclk = 1'b0; // data held across the cut clock fall
			r_next.frame = 1'b0;
		end else begin
			unique case (r_reg.state)
				APC_OFF: begin
					r_next.state = APC_SETTLE;
					r_next.cnt = SETTLE_CLKS;
				end
				APC_SETTLE: begin
					fifo_pop = fifo_valid; // unsettled words are dropped
					r_next.dout = 1'b0; // parked low once the serial clock is low
					if (r_reg.cnt == '0) begin
						r_next.state = APC_IDLE;
					end else begin
						r_next.cnt = r_reg.cnt - 10'd1;
					end
				end
				APC_IDLE: begin
					if (fifo_valid) begin
						fifo_pop = 1'b1;
						r_next = load_word(r_next, fifo_data);
					end
				end
				APC_SHIFT: begin
					if (r_reg.sclk) begin
						r_next.sclk = 1'b0;
						r_next.frame = 1'b0;
					end else if (r_reg.bit_idx == LAST_BIT) begin
						if (fifo_valid) begin
							fifo_pop = 1'b1;
							r_next = load_word(r_next, fifo_data);
						end else begin
							r_next.state = APC_IDLE;
							r_next.dout = 1'b0;
						end
					end else begin
						r_next.sclk = 1'b1;
						r_next.bit_idx = r_reg.bit_idx + 4'd1;
						r_next.shreg = {r_reg.shreg[14:0], 1'b0};
						r_next.dout = r_reg.shreg[14];
					end
				end
			endcase
		end
		r_next.enable = r_reg.pd_s2 && (r_next.state != APC_OFF);
		r_next.hold = r_next.enable;
		r_next.vref_on = !r_reg.vref_s2 && r_reg.pd_s2;
		r_next.sclk_n = !r_next.sclk;
		r_next.dout_n = !r_next.dout;
		r_next.frame_n = !r_next.frame;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			r_reg <= TOP_RESET;
		end else begin
			r_reg <= r_next;
		end
	end

	assign sclk = r_reg.sclk;
	assign sclk_n = r_reg.sclk_n;
	assign dout = r_reg.dout;
	assign dout_n = r_reg.dout_n;
	assign frame_marker = r_reg.frame;
	assign frame_marker_n = r_reg.frame_n;
	assign range_exceeded = r_reg.range;
	assign internal_vref_on = r_reg.vref_on;
	assign circuit_enable = r_reg.enable;
	assign sample_hold = r_reg.hold;

	// checks on the output framing and pin control
	property p_frame_one;
		@(posedge clk) disable iff (reset) frame_marker |=> !frame_marker;
	endproperty
	a_frame_one: assert property (p_frame_one) else $error("marker longer than one clock");

	property p_frame_on_rise;
		@(posedge clk) disable iff (reset) $rose(frame_marker) |-> $rose(sclk);
	endproperty
	a_frame_on_rise: assert property (p_frame_on_rise) else $error("marker not on clock rise");

	property p_compl;
		@(posedge clk) disable iff (reset)
			(sclk_n != sclk) && (dout_n != dout) && (frame_marker_n != frame_marker);
	endproperty
	a_compl: assert property (p_compl) else $error("complement copy mismatch");

	property p_sclk_half;
		@(posedge clk) disable iff (reset) sclk |=> !sclk;
	endproperty
	a_sclk_half: assert property (p_sclk_half) else $error("serial clock high too long");

	property p_dout_hold;
		@(posedge clk) disable iff (reset) (circuit_enable && $fell(sclk)) |-> $stable(dout);
	endproperty
	a_dout_hold: assert property (p_dout_hold) else $error("data moved on clock fall");

	property p_pd;
		@(posedge clk) disable iff (reset)
			!r_reg.pd_s2 |=> (!circuit_enable && !sclk && !frame_marker && !sample_hold);
	endproperty
	a_pd: assert property (p_pd) else $error("power down not honoured");

	property p_vref;
		@(posedge clk) disable iff (reset)
			(r_reg.pd_s2 && r_reg.vref_s2) |=> !internal_vref_on;
	endproperty
	a_vref: assert property (p_vref) else $error("internal reference left on");

	property p_settle_quiet;
		@(posedge clk) disable iff (reset) sync_evt |=> !frame_marker [*8];
	endproperty
	a_settle_quiet: assert property (p_settle_quiet) else $error("frame during settling");

	property p_saturate;
		@(posedge clk) disable iff (reset)
			(sample_data[17:15] == 3'h1) |->
				(fifo_in_data[16] && fifo_in_data[15:0] == POS_FULL);
	endproperty
	a_saturate: assert property (p_saturate) else $error("positive clamp wrong");

	property p_hold;
		@(posedge clk) disable iff (reset) circuit_enable |-> sample_hold;
	endproperty
	a_hold: assert property (p_hold) else $error("sampling not running");

	c_frame: cover property (@(posedge clk) disable iff (reset) $rose(frame_marker));
	c_range: cover property (@(posedge clk) disable iff (reset) $rose(range_exceeded));
	c_sync: cover property (@(posedge clk) disable iff (reset) sync_evt ##[1:900] frame_marker);
	c_pd: cover property (@(posedge clk) disable iff (reset) $fell(circuit_enable));
endmodule
`default_nettype wire

/* File: design/apc_pkg.sv */
// constants, types and helpers for the converter pin control and serial output
package apc_pkg;
	// clock and timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int SETTLE_MAX_PERIODS = 833;
	localparam logic [9:0] SETTLE_CLKS = 10'd800;
	// word format
	localparam int IN_BITS = 18;
	localparam int WORD_BITS = 16;
	localparam logic [3:0] LAST_BIT = 4'hF;
	localparam logic [15:0] POS_FULL = 16'h7FFF;
	localparam logic [15:0] NEG_FULL = 16'h8000;
	// buffering
	localparam int FIFO_DEPTH = 4;
	localparam int FIFO_WIDTH = WORD_BITS + 1;
	// reset values of the pin synchronisers (pull-up / pull-down defaults)
	localparam logic PD_N_RESET = 1'b1;
	localparam logic VREF_N_RESET = 1'b0;

	typedef enum logic [1:0] {APC_OFF, APC_SETTLE, APC_IDLE, APC_SHIFT} apc_state_e;

	// clamp the wide filter result to a 16-bit word plus range flag
	function automatic logic [16:0] apc_saturate(input logic [17:0] s);
		if (s[17:15] == 3'h0 || s[17:15] == 3'h7) begin
			return {1'b0, s[15:0]};
		end else if (s[17]) begin
			return {1'b1, NEG_FULL};
		end else begin
			return {1'b1, POS_FULL};
		end
	endfunction
endpackage

/* File: design/apc_fifo.sv */
// small show-ahead fifo with registered outputs
`timescale 1ns/1ps
`default_nettype none
module apc_fifo #(
	parameter int WIDTH = 17,
	parameter int DEPTH = 4
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] wr;
		logic [PW-1:0] rd;
		logic [CW-1:0] cnt;
		logic in_ready;
		logic out_valid;
		logic [WIDTH-1:0] out_data;
	} apc_fifo_s;

	apc_fifo_s r_reg;
	apc_fifo_s r_next;

	function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
		return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
	endfunction

	// pointer, count and registered view of the head
	always_comb begin
		logic push;
		logic pop;
		push = in_valid && r_reg.in_ready;
		pop = out_ready && r_reg.out_valid;
		r_next = r_reg;
		if (push) begin
			r_next.mem[r_reg.wr] = in_data;
			r_next.wr = bump(r_reg.wr);
		end
		if (pop) begin
			r_next.rd = bump(r_reg.rd);
		end
		r_next.cnt = r_reg.cnt + CW'(push) - CW'(pop);
		if (flush) begin
			r_next.wr = '0;
			r_next.rd = '0;
			r_next.cnt = '0;
		end
		r_next.in_ready = (r_next.cnt != CW'(DEPTH));
		r_next.out_valid = (r_next.cnt != '0);
		r_next.out_data = r_next.mem[r_next.rd];
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign in_ready = r_reg.in_ready;
	assign out_valid = r_reg.out_valid;
	assign out_data = r_reg.out_data;
endmodule
`default_nettype wire

/* File: testbench/apc_rx_model.sv */
// serial receiver model: takes framed words on the serial clock fall
`timescale 1ns/1ps
`default_nettype none
module apc_rx_model (
	input wire logic clk,
	input wire logic reset,
	input wire logic sclk,
	input wire logic dout,
	input wire logic frame_marker,
	input wire logic range_exceeded,
	output logic [16:0] rx_word,
	output logic rx_strobe
);
	logic sclk_reg;
	logic in_word;
	logic flag_reg;
	logic [4:0] bit_cnt;
	logic [15:0] shift_reg;
	// a frame opens a word; each serial clock fall takes one bit, msb first
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			sclk_reg <= 1'b0;
			in_word <= 1'b0;
			flag_reg <= 1'b0;
			bit_cnt <= 5'h00;
			shift_reg <= 16'h0000;
			rx_word <= 17'h00000;
			rx_strobe <= 1'b0;
		end else begin
			sclk_reg <= sclk;
			rx_strobe <= 1'b0;
			if (frame_marker && sclk) begin
				in_word <= 1'b1;
				bit_cnt <= 5'h00;
				flag_reg <= range_exceeded;
			end else if (in_word && sclk_reg && !sclk) begin
				shift_reg <= {shift_reg[14:0], dout};
				bit_cnt <= bit_cnt + 5'h01;
				if (bit_cnt == 5'h0F) begin
					in_word <= 1'b0;
					rx_strobe <= 1'b1;
					rx_word <= {flag_reg, shift_reg[14:0], dout};
				end
			end
		end
	end
endmodule
`default_nettype wire

/* File: testbench/adc_pin_control_serial_out_test.sv */
// self-checking bench for the converter pin control and serial output
`timescale 1ns/1ps
`default_nettype none
module adc_pin_control_serial_out_test;
	import apc_pkg::*;
	logic clk, reset, sample_valid, sync_pin, power_down_n, use_internal_vref_n;
	logic [IN_BITS-1:0] sample_data;
	logic sample_ready, sclk, sclk_n, dout, dout_n, frame_marker, frame_marker_n;
	logic range_exceeded, internal_vref_on, circuit_enable, sample_hold, rx_strobe;
	logic [16:0] rx_word;
	logic frame_prev, saw_full;
	logic [16:0] rx_q[$];
	logic [16:0] exp_q[$];
	int failures, tests_run, cnt;
	apc_top dut (.clk(clk), .reset(reset), .sample_valid(sample_valid),
		.sample_ready(sample_ready), .sample_data(sample_data), .sync_pin(sync_pin),
		.power_down_n(power_down_n), .use_internal_vref_n(use_internal_vref_n),
		.sclk(sclk), .sclk_n(sclk_n), .dout(dout), .dout_n(dout_n),
		.frame_marker(frame_marker), .frame_marker_n(frame_marker_n),
		.range_exceeded(range_exceeded), .internal_vref_on(internal_vref_on),
		.circuit_enable(circuit_enable), .sample_hold(sample_hold));
	apc_rx_model rx (.clk(clk), .reset(reset), .sclk(sclk), .dout(dout),
		.frame_marker(frame_marker), .range_exceeded(range_exceeded),
		.rx_word(rx_word), .rx_strobe(rx_strobe));
	// clock
	initial begin
		clk = 1'b0;
		forever #(CLK_PERIOD_NS / 2) clk = ~clk;
	end
	task automatic check(input logic [17:0] seen, input logic [17:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR t=%0t seen=%0h expected=%0h", $time, seen, exp);
		end
	endtask
	// expected word and range flag of a wide sample
	function automatic logic [16:0] clamp(input logic [17:0] s);
		if (s[17:15] == 3'h0 || s[17:15] == 3'h7) return {1'b0, s[15:0]};
		return s[17] ? {1'b1, NEG_FULL} : {1'b1, POS_FULL};
	endfunction
	task automatic wait_clks(input int n);
		repeat (n) @(posedge clk);
	endtask
	// back-to-back pushes: corner codes first, then random values
	task automatic push_words(input int n);
		logic [17:0] corner[4] = '{18'h07FFF, 18'h38000, 18'h08000, 18'h37FFF};
		logic [17:0] d;
		int g;
		for (int i = 0; i < n; i++) begin
			d = (i < 4) ? corner[i] : 18'($urandom);
			sample_valid <= 1'b1;
			sample_data <= d;
			g = 0;
			do begin
				@(posedge clk);
				g++;
				if (!sample_ready) saw_full = 1'b1;
			end while (!(sample_ready && circuit_enable) && g < 400);
			exp_q.push_back(clamp(d));
		end
		sample_valid <= 1'b0;
	endtask
	// wait for every pushed word at the receiver, then compare in order
	task automatic drain();
		cnt = 0;
		while (rx_q.size() < exp_q.size() && cnt < 5000) begin
			@(posedge clk);
			cnt++;
		end
		check(18'(rx_q.size()), 18'(exp_q.size()));
		foreach (exp_q[i]) if (i < rx_q.size()) check(rx_q[i], exp_q[i]);
		rx_q.delete();
		exp_q.delete();
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// collect received words
	always @(posedge clk) if (rx_strobe) rx_q.push_back(rx_word);
	// line pairs and frame shape, every cycle
	always @(negedge clk) begin
		if (!reset) begin
			check({sclk_n, dout_n, frame_marker_n}, {~sclk, ~dout, ~frame_marker});
			if (frame_marker) check({frame_prev, sclk}, 2'b01);
		end
		frame_prev = frame_marker;
	end
	// watchdog
	initial begin
		wait_clks(20000);
		failures++;
		tally_and_finish();
	end
	initial begin
		failures = 0;
		tests_run = 0;
		saw_full = 1'b0;
		frame_prev = 1'b0;
		reset = 1'b1;
		sample_valid = 1'b0;
		sample_data = '0;
		sync_pin = 1'b0;
		power_down_n = 1'b1;
		use_internal_vref_n = 1'b0;
		void'($urandom(32'hf424));
		wait_clks(2);
		check({sclk_n, dout_n, frame_marker_n, sclk, dout, frame_marker, sample_ready}, 7'h70);
		reset <= 1'b0;
		wait_clks(SETTLE_CLKS + 10);
		check({circuit_enable, internal_vref_on, sample_hold}, 3'h7);
		$display("test reset and settle done");
		push_words(12);
		drain();
		check(saw_full, 1'b1);
		$display("test stream and clamp done");
		sample_valid <= 1'b1;
		sample_data <= 18'($urandom);
		sync_pin <= 1'b1;
		cnt = 0;
		do begin
			@(posedge clk);
			cnt++;
			if (cnt == 2) sync_pin <= 1'b0;
		end while (!(cnt > 6 && frame_marker) && cnt < 1000);
		check(18'(cnt <= SETTLE_MAX_PERIODS + 3), 18'h1);
		sample_valid <= 1'b0;
		wait_clks(200);
		rx_q.delete();
		$display("test alignment done");
		use_internal_vref_n <= 1'b1;
		wait_clks(5);
		check(internal_vref_on, 1'b0);
		use_internal_vref_n <= 1'b0;
		wait_clks(5);
		check(internal_vref_on, 1'b1);
		$display("test reference select done");
		power_down_n <= 1'b0;
		wait_clks(6);
		check({circuit_enable, internal_vref_on, sample_hold, sclk, frame_marker}, 5'h00);
		power_down_n <= 1'b1;
		wait_clks(SETTLE_CLKS + 10);
		push_words(6);
		drain();
		$display("test power down done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
